// file: core/bank_tx_ctrl.sv
/*
  Bank selector and transmit control register with the transmit
  option logic they steer. Assumes a host I/O bus on clk with a
  registered read answer one cycle after rd, and a transmitter that
  reports its events as same-clock pulses.
*/
// Function
// R1 - Codes 0-4 pick a bank, 5-7 none
// R2 - Selector reachable always, except power down
// R3 - Selector upper byte reads constant 33h
// R4 - Missing bank: drop writes, bytes read 33h
// R5 - Suppress-FCS bit stops CRC append, resets zero
// R6 - Switched duplex: no deferral, no collision detect
// R7 - Switched duplex forces duplex on, monitor off
// R8 - Style low: starve when DMA passes pointer
// R9 - Style high: starve on packet match, overtaking
// R10 - Handler loopback bypasses encoder, resets low
// R11 - Host soft-resets after leaving handler loopback
// R12 - Halt bit: SQE error stops transmitter
// R13 - Duplex bit decides accepting own frames
// R14 - Host writes zero to reserved transmit bit
// R15 - Carrier monitor aborts frame, disables transmitter
// R16 - Padding fills short frames with zeros
// R17 - Host writes unpadded byte count
// R18 - Forced collision: no deferral, self-clearing
// R19 - Local loopback: ignore collision, no network
// R20 - Finish frame on disable; errors clear enable
// R21 - Underrun sets flag, clears enable
// R22 - Handler loop over local over external
module bank_tx_ctrl
  import tx_ctrl_pkg::*;
#(
  parameter int unsigned ADDR_W = 11,
  parameter int unsigned PNUM_W = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire io_req_t io_req,
  input wire logic [15:0] ext_rdata,
  input wire logic power_down,
  input wire logic soft_rst,
  input wire logic early_tx_enable,
  input wire tx_evt_t tx_evt,
  input wire logic crs_pin,
  input wire logic rx_addr_pass,
  input wire logic rx_from_self,
  input wire logic [ADDR_W-1:0] dma_addr,
  input wire logic [ADDR_W-1:0] host_ptr,
  input wire logic [PNUM_W-1:0] load_pnum,
  input wire logic [PNUM_W-1:0] tx_pnum,
  input wire logic [ADDR_W-1:0] tx_laddr,
  input wire logic [ADDR_W-1:0] load_laddr,
  output logic [15:0] io_rdata_q,
  output logic io_rvalid_q,
  output logic [2:0] bank_q,
  output logic bank_live_q,
  output tx_cfg_t cfg_q,
  output logic tx_run_q,
  output logic underrun_flag_q,
  output logic abort_suppress_fcs_append_q,
  output logic starve_dma_q,
  output logic rx_accept_q
);

  if (ADDR_W > 16 || PNUM_W > 8) begin : g_chk
    $error("bank_tx_ctrl pointer widths out of range");
  end

  logic [15:0] tcr_q;
  logic [15:0] tcr_d;
  logic [15:0] tcr_wr;
  logic [15:0] rdata_d;
  logic crs_meta_q;
  logic crs_q;
  logic bsr_hit;
  logic tcr_hit;
  logic bank_ok;
  logic bsr_wr;
  logic tcr_wr_en;
  logic err_stop;
  logic carrier_fault;
  logic starve;
  logic switched_full_duplex;
  logic eff_mon;
  logic transmit_enable_bit_set;
  loop_point_t loop_d;

  // Carrier arrives from the line, two flops before use
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      crs_meta_q <= 1'b0;
      crs_q <= 1'b0;
    end else begin
      crs_meta_q <= crs_pin;
      crs_q <= crs_meta_q;
    end
  end

  // Address decode; selector word answers in every bank
  assign bank_ok = bank_q <= BANK_LAST; // R1
  assign bsr_hit = (io_req.addr[3:1] == BSR_OFS[3:1]) &&
                   !power_down; // R2
  assign tcr_hit = (io_req.addr[3:1] == TCR_OFS[3:1]) &&
                   (bank_q == BANK_RST);
  assign bsr_wr = io_req.wr && bsr_hit && io_req.be[0];
  assign tcr_wr_en = io_req.wr && tcr_hit;

  // Bank index, low byte lane only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bank_q <= BANK_RST;
    end else if (soft_rst) begin
      bank_q <= BANK_RST;
    end else if (bsr_wr) begin
      bank_q <= io_req.wdata[2:0]; // R1
    end
  end

  // Tells the other register blocks whether the bank exists
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bank_live_q <= 1'b1;
    end else if (soft_rst) begin
      bank_live_q <= 1'b1;
    end else if (bsr_wr) begin
      bank_live_q <= io_req.wdata[2:0] <= BANK_LAST; // R4
    end
  end

  // Byte-lane merge of a host write into the control word
  always_comb begin
    tcr_wr = tcr_q;
    if (io_req.be[0]) begin
      tcr_wr[7:0] = io_req.wdata[7:0];
    end
    if (io_req.be[1]) begin
      tcr_wr[15:8] = io_req.wdata[15:8];
    end
    tcr_wr = tcr_wr & TCR_WMASK;
  end

  // Fatal conditions that stop the transmitter
  assign err_stop = tx_evt.underrun || tx_evt.late_col ||
                    tx_evt.col16 || carrier_fault || // R15
                    (tx_evt.sqe_fail && tcr_q[TCR_STPSQE]); // R12

  assign transmit_enable_bit_set = tcr_wr_en && io_req.be[0] &&
                     io_req.wdata[TCR_TRANSMIT_ENABLE_BIT];

  // Host writes, then hardware clears on top of them
  always_comb begin
    tcr_d = tcr_q;
    if (tcr_wr_en) begin
      tcr_d = tcr_wr;
    end
    if (err_stop) begin
      tcr_d[TCR_TRANSMIT_ENABLE_BIT] = 1'b0; // R20
    end
    if (tx_evt.collision && tcr_q[TCR_FORCED_COLLISION]) begin
      tcr_d[TCR_FORCED_COLLISION] = 1'b0; // R18
    end
  end

  // Control word; soft reset drops it back to defaults
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tcr_q <= TCR_RST; // R5
    end else if (soft_rst) begin
      tcr_q <= TCR_RST; // R11
    end else begin
      tcr_q <= tcr_d;
    end
  end

  // Underrun flag; a new underrun beats the host re-enable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      underrun_flag_q <= 1'b0;
    end else if (tx_evt.underrun) begin
      underrun_flag_q <= 1'b1; // R21
    end else if (transmit_enable_bit_set || soft_rst) begin
      underrun_flag_q <= 1'b0; // R21
    end
  end

  // Read data; missing banks answer the fixed byte in both lanes
  always_comb begin
    rdata_d = 16'h0000;
    if (bsr_hit) begin
      rdata_d = {BSR_SIG, 5'h00, bank_q}; // R3
    end else if (power_down &&
                 io_req.addr[3:1] == BSR_OFS[3:1]) begin
      rdata_d = 16'h0000;
    end else if (!bank_ok) begin
      rdata_d = {NOBANK_BYTE, NOBANK_BYTE}; // R4
    end else if (tcr_hit) begin
      rdata_d = tcr_q;
    end else begin
      rdata_d = ext_rdata;
    end
  end

  // Answer one cycle after the read strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      io_rdata_q <= 16'h0000;
      io_rvalid_q <= 1'b0;
    end else begin
      io_rvalid_q <= io_req.rd;
      if (io_req.rd) begin
        io_rdata_q <= rdata_d;
      end
    end
  end

  // Loop point: handler first, then local, else none
  always_comb begin
    loop_d = LOOP_NONE;
    if (tcr_q[TCR_EPHLOOP]) begin
      loop_d = LOOP_HANDLER; // R10
    end else if (tcr_q[TCR_LOOP]) begin
      loop_d = LOOP_ENDEC; // R19
    end
  end

  assign switched_full_duplex = tcr_q[TCR_SWITCHED_FULL_DUPLEX];
  assign eff_mon = tcr_q[TCR_MON] && !switched_full_duplex; // R7

  // Effective settings for the transmit path
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_q.crc_append <= 1'b1;
      cfg_q.pad <= 1'b0;
      cfg_q.no_defer <= 1'b0;
      cfg_q.col_detect_en <= 1'b1;
      cfg_q.eff_fdx <= 1'b0;
      cfg_q.eff_mon <= 1'b0;
      cfg_q.halt_sqe <= 1'b0;
      cfg_q.net_drive_en <= 1'b1;
      cfg_q.ignore_col_crs <= 1'b0;
      cfg_q.loop_point <= LOOP_NONE;
    end else begin
      cfg_q.crc_append <= !tcr_q[TCR_SUPPRESS_FCS_APPEND]; // R5
      cfg_q.pad <= tcr_q[TCR_PAD]; // R16
      cfg_q.no_defer <= switched_full_duplex || tcr_q[TCR_FORCED_COLLISION]; // R6 R18
      cfg_q.col_detect_en <= !switched_full_duplex && !tcr_q[TCR_LOOP]; // R6 R19
      cfg_q.eff_fdx <= tcr_q[TCR_OWN_FRAME_FULL_DUPLEX] || switched_full_duplex; // R7
      cfg_q.eff_mon <= eff_mon;
      cfg_q.halt_sqe <= tcr_q[TCR_STPSQE]; // R12
      cfg_q.net_drive_en <= loop_d == LOOP_NONE; // R22
      cfg_q.ignore_col_crs <= loop_d == LOOP_ENDEC; // R19
      cfg_q.loop_point <= loop_d; // R22
    end
  end

  // Transmitter runs while enabled or finishing its frame
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_run_q <= 1'b0;
    end else begin
      tx_run_q <= (tcr_d[TCR_TRANSMIT_ENABLE_BIT] ||
                   (tx_evt.busy && !err_stop)) && !soft_rst; // R20
    end
  end

  // Frame is cut without CRC when carrier goes missing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      abort_suppress_fcs_append_q <= 1'b0;
    end else begin
      abort_suppress_fcs_append_q <= carrier_fault; // R15
    end
  end

  // Own-frame filtering for the receive path
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_accept_q <= 1'b0;
    end else begin
      rx_accept_q <= rx_addr_pass &&
                     (tcr_q[TCR_OWN_FRAME_FULL_DUPLEX] || switched_full_duplex ||
                      !rx_from_self); // R13 R7
    end
  end

  // Only the active early-transmit style may starve the DMA
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      starve_dma_q <= 1'b0;
    end else begin
      starve_dma_q <= starve && tcr_q[TCR_TRANSMIT_ENABLE_BIT];
    end
  end

  underrun_guard #(
    .ADDR_W(ADDR_W),
    .PNUM_W(PNUM_W)
  ) u_guard (
    .clk(clk),
    .rst(rst),
    .early_en(early_tx_enable),
    .style(tcr_q[TCR_ETYPE]),
    .dma_addr(dma_addr),
    .host_ptr(host_ptr),
    .load_pnum(load_pnum),
    .tx_pnum(tx_pnum),
    .tx_laddr(tx_laddr),
    .load_laddr(load_laddr),
    .starve_q(starve)
  );

  // Local loopback ignores carrier, so the monitor is gated off
  carrier_watch u_crs (
    .clk(clk),
    .rst(rst),
    .enable(eff_mon && !tcr_q[TCR_LOOP]),
    .busy(tx_evt.busy),
    .preamble_end(tx_evt.preamble_end),
    .crs(crs_q),
    .fault_q(carrier_fault)
  );

endmodule // bank_tx_ctrl

// file: core/carrier_watch.sv
/*
  Own-carrier monitor for the transmitter. Flags a frame whose carrier
  is missing at the end of preamble or drops later in the frame.
  Assumes crs is already synchronised to clk.
*/
module carrier_watch
  import tx_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic busy,
  input wire logic preamble_end,
  input wire logic crs,
  output logic fault_q
);

  logic armed_q;

  // Armed from end of preamble until the frame ends or faults
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      armed_q <= 1'b0;
    end else if (!busy || !enable || fault_q) begin
      armed_q <= 1'b0;
    end else if (preamble_end && crs) begin
      armed_q <= 1'b1;
    end
  end

  // One pulse per faulty frame
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= enable && busy && !fault_q &&
                 ((preamble_end && !crs) || (armed_q && !crs)); // R15
    end
  end

endmodule // carrier_watch

// file: core/tx_ctrl_pkg.sv
/*
  Shared constants and types for the bank selector and transmit control
  block. Assumes a 16-bit host I/O window of 16 byte locations.
*/
package tx_ctrl_pkg;

  // Register locations within the I/O window
  localparam logic [3:0] BSR_OFS = 4'he;
  localparam logic [3:0] TCR_OFS = 4'h0;

  // Bank selector values
  localparam logic [2:0] BANK_RST = 3'h0;
  localparam logic [2:0] BANK_LAST = 3'h4;
  localparam logic [7:0] BSR_SIG = 8'h33;
  localparam logic [7:0] NOBANK_BYTE = 8'h33;

  // Transmit control bit positions
  localparam int unsigned TCR_TRANSMIT_ENABLE_BIT = 0;
  localparam int unsigned TCR_LOOP = 1;
  localparam int unsigned TCR_FORCED_COLLISION = 2;
  localparam int unsigned TCR_TXP = 3;
  localparam int unsigned TCR_PAD = 7;
  localparam int unsigned TCR_SUPPRESS_FCS_APPEND = 8;
  localparam int unsigned TCR_MON = 10;
  localparam int unsigned TCR_OWN_FRAME_FULL_DUPLEX = 11;
  localparam int unsigned TCR_STPSQE = 12;
  localparam int unsigned TCR_EPHLOOP = 13;
  localparam int unsigned TCR_ETYPE = 14;
  localparam int unsigned TCR_SWITCHED_FULL_DUPLEX = 15;

  // Reset value and the bits that hold state
  localparam logic [15:0] TCR_RST = 16'h0000;
  localparam logic [15:0] TCR_WMASK = 16'hfd8f;

  // Host I/O request, same clock as the block
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [1:0] be;
    logic [15:0] wdata;
  } io_req_t;

  // Events reported by the transmitter, one-cycle pulses except busy
  typedef struct packed {
    logic busy;
    logic preamble_end;
    logic collision;
    logic underrun;
    logic sqe_fail;
    logic late_col;
    logic col16;
  } tx_evt_t;

  typedef enum logic [1:0] {
    LOOP_NONE,
    LOOP_ENDEC,
    LOOP_HANDLER
  } loop_point_t;

  // Effective settings handed to the transmit and receive logic
  typedef struct packed {
    logic crc_append;
    logic pad;
    logic no_defer;
    logic col_detect_en;
    logic eff_fdx;
    logic eff_mon;
    logic halt_sqe;
    logic net_drive_en;
    logic ignore_col_crs;
    loop_point_t loop_point;
  } tx_cfg_t;

endpackage

// file: core/underrun_guard.sv
/*
  Early transmit underrun detector. Compares the transmit DMA position
  against the loading position and asks for the DMA to be starved.
  Assumes all inputs come from logic on the same clock.
*/
module underrun_guard
  import tx_ctrl_pkg::*;
#(
  parameter int unsigned ADDR_W = 11,
  parameter int unsigned PNUM_W = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic early_en,
  input wire logic style,
  input wire logic [ADDR_W-1:0] dma_addr,
  input wire logic [ADDR_W-1:0] host_ptr,
  input wire logic [PNUM_W-1:0] load_pnum,
  input wire logic [PNUM_W-1:0] tx_pnum,
  input wire logic [ADDR_W-1:0] tx_laddr,
  input wire logic [ADDR_W-1:0] load_laddr,
  output logic starve_q
);

  if (ADDR_W < 1 || PNUM_W < 1) begin : g_chk
    $error("underrun_guard widths must be positive");
  end

  logic starve_d;

  // Style picks packet-aware or plain pointer comparison
  always_comb begin
    starve_d = 1'b0;
    if (early_en) begin
      if (style) begin
        starve_d = (load_pnum == tx_pnum) && (tx_laddr > load_laddr); // R9
      end else begin
        starve_d = dma_addr > host_ptr; // R8
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      starve_q <= 1'b0;
    end else begin
      starve_q <= starve_d;
    end
  end

endmodule // underrun_guard

// file: verification/bank_tx_ctrl_monitor.sv
/*
  Port checker for bank_tx_ctrl.
  Assumes it is bound to the block, all inputs on clk.
*/
module bank_tx_ctrl_monitor
  import tx_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire io_req_t io_req,
  input wire logic power_down,
  input wire logic soft_rst,
  input wire tx_evt_t tx_evt,
  input wire logic [15:0] io_rdata_q,
  input wire logic [2:0] bank_q,
  input wire tx_cfg_t cfg_q,
  input wire logic tx_run_q,
  input wire logic underrun_flag_q,
  input wire logic abort_suppress_fcs_append_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Selector answers
  property p_sig;
    io_req.rd && io_req.addr[3:1] == 3'h7 && !power_down
      |=> io_rdata_q[15:8] == BSR_SIG;
  endproperty
  a_sig: assert property (p_sig) else $error("bad signature");
  property p_pd;
    io_req.rd && power_down && io_req.addr[3:1] == 3'h7
      |=> io_rdata_q == 16'h0000;
  endproperty
  a_pd: assert property (p_pd) else $error("selector seen in power down");
  property p_nobank;
    io_req.rd && bank_q > BANK_LAST && io_req.addr[3:1] != 3'h7
      |=> io_rdata_q == {2{NOBANK_BYTE}};
  endproperty
  a_nobank: assert property (p_nobank) else $error("missing bank read");
  property p_bank;
    io_req.wr && io_req.be[0] && io_req.addr[3:1] == 3'h7 && !power_down
      && !soft_rst |=> bank_q == $past(io_req.wdata[2:0]);
  endproperty
  a_bank: assert property (p_bank) else $error("bank not taken");

  // Settings follow the control word two cycles on
  property p_cfg;
    io_req.wr && io_req.addr[3:1] == 3'h0 && bank_q == 3'h0 && &io_req.be
      && !soft_rst |-> ##2 cfg_q.pad == $past(io_req.wdata[TCR_PAD], 2)
      && cfg_q.crc_append != $past(io_req.wdata[TCR_SUPPRESS_FCS_APPEND], 2);
  endproperty
  a_cfg: assert property (p_cfg) else $error("pad or crc wrong");
  property p_switched_full_duplex;
    !cfg_q.col_detect_en && cfg_q.net_drive_en
      |-> cfg_q.eff_fdx && !cfg_q.eff_mon;
  endproperty
  a_switched_full_duplex: assert property (p_switched_full_duplex) else $error("switched duplex");
  property p_loop;
    cfg_q.loop_point != LOOP_NONE |-> !cfg_q.net_drive_en;
  endproperty
  a_loop: assert property (p_loop) else $error("loop drives net");

  // Transmitter error handling
  property p_ur;
    tx_evt.underrun |=> underrun_flag_q;
  endproperty
  a_ur: assert property (p_ur) else $error("underrun flag");
  property p_err;
    tx_evt.underrun ##1 (!tx_evt.busy && !io_req.wr)[*2] |=> !tx_run_q;
  endproperty
  a_err: assert property (p_err) else $error("still running");
  property p_abort;
    abort_suppress_fcs_append_q |-> cfg_q.eff_mon ##1 !abort_suppress_fcs_append_q;
  endproperty
  a_abort: assert property (p_abort) else $error("abort pulse");
endmodule // bank_tx_ctrl_monitor

// file: verification/bank_tx_ctrl_tb.sv
/*
  Self-checking bench for bank_tx_ctrl with a host model.
  Assumes the package constants and default widths.
*/
module bank_tx_ctrl_tb
  import tx_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, soft_rst, power_down, early_tx_enable;
  logic crs_pin, rx_addr_pass, rx_from_self, ab;
  logic io_rvalid_q, bank_live_q, tx_run_q, underrun_flag_q;
  logic abort_suppress_fcs_append_q, starve_dma_q, rx_accept_q;
  logic [15:0] ext_rdata, io_rdata_q, d;
  logic [10:0] dma_addr, host_ptr, tx_laddr, load_laddr;
  logic [4:0] load_pnum, tx_pnum;
  logic [2:0] bank_q;
  io_req_t io_req;
  tx_evt_t tx_evt;
  tx_cfg_t cfg_q;
  logic [15:0] exp_q[$];
  int errors = 0, checked = 0, cyc = 0;

  always #20 clk = ~clk;

  io_host_model host (.clk, .io_req, .soft_rst);
  bank_tx_ctrl dut (.clk, .rst, .io_req, .ext_rdata, .power_down,
    .soft_rst, .early_tx_enable, .tx_evt, .crs_pin, .rx_addr_pass,
    .rx_from_self, .dma_addr, .host_ptr, .load_pnum, .tx_pnum,
    .tx_laddr, .load_laddr, .io_rdata_q, .io_rvalid_q, .bank_q,
    .bank_live_q, .cfg_q, .tx_run_q, .underrun_flag_q, .abort_suppress_fcs_append_q,
    .starve_dma_q, .rx_accept_q);

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic complete_run();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Read request; the answer is noted for the watcher
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    host.rd(a);
  endtask
  task automatic pulse(input logic [6:0] e);
    @(posedge clk) tx_evt <= tx_evt | e;
    @(posedge clk) tx_evt <= tx_evt & ~e;
  endtask
  // Settings expected from a control word without handler loop
  function automatic tx_cfg_t ecfg(input logic [15:0] w);
    loop_point_t lp;
    lp = w[1] ? LOOP_ENDEC : LOOP_NONE;
    return '{!w[8], w[7], w[15] | w[2], !w[15] & !w[1], w[15] | w[11],
      w[10] & !w[15], w[12], !w[1], w[1], lp};
  endfunction

  // Watcher pairs each read answer with the oldest note
  always @(negedge clk) begin
    if (io_rvalid_q === 1'b1) begin
      if (exp_q.size() == 0) chk(io_rdata_q, 16'hxxxx);
      else chk(io_rdata_q, exp_q.pop_front());
    end
  end
  // Hang guard, far above the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      complete_run();
    end
  end

  initial begin
    {power_down, early_tx_enable, crs_pin} = '0;
    {rx_addr_pass, rx_from_self, tx_evt} = '0;
    {dma_addr, host_ptr, tx_laddr, load_laddr, load_pnum, tx_pnum} = '0;
    void'($urandom(49));
    ext_rdata = 16'($urandom);
    cy(4);
    rst <= 1'b0;
    cy(1);
    chk(16'(cfg_q), 16'(ecfg(16'h0)));
    rd(4'h0, TCR_RST);
    // Every bank code, with writes into missing banks
    for (int b = 0; b < 8; b++) begin
      host.wr(4'he, 2'h1, 16'(b));
      rd(4'he, {BSR_SIG, 5'h0, 3'(b)});
      chk(16'(bank_live_q), 16'(b <= 4));
      if (b > 4) begin
        host.wr(4'h0, 2'h3, 16'hfff7);
        rd(4'h0, {2{NOBANK_BYTE}});
        rd(4'h6, {2{NOBANK_BYTE}});
      end else if (b > 0) begin
        rd(4'h6, ext_rdata);
      end
    end
    host.wr(4'he, 2'h1, 16'h0);
    rd(4'h0, 16'h0);
    // Selector shut off in power down
    power_down <= 1'b1;
    host.wr(4'he, 2'h1, 16'h3);
    rd(4'he, 16'h0);
    power_down <= 1'b0;
    rd(4'he, {BSR_SIG, 8'h0});
    // Random control words
    for (int i = 0; i < 8; i++) begin
      d = 16'($urandom) & 16'hdff7;
      host.wr(4'h0, 2'h3, d);
      cy(3);
      chk(16'(cfg_q), 16'(ecfg(d)));
      rd(4'h0, d & TCR_WMASK);
    end
    host.wr(4'h0, 2'h3, 16'h2002);
    cy(3);
    chk(16'({cfg_q.loop_point, cfg_q.net_drive_en}), 16'h4);
    host.leave_loop();
    cy(3);
    chk(16'({cfg_q.loop_point, cfg_q.net_drive_en}), 16'h1);
    // Underrun, then re-enable clears the flag
    host.wr(4'h0, 2'h3, 16'h0001);
    cy(2);
    pulse(7'h08);
    cy(2);
    chk(16'({underrun_flag_q, tx_run_q}), 16'h2);
    host.wr(4'h0, 2'h3, 16'h0001);
    cy(2);
    chk(16'({underrun_flag_q, tx_run_q}), 16'h1);
    // Disable waits for the frame in progress
    tx_evt.busy <= 1'b1;
    host.wr(4'h0, 2'h3, 16'h0000);
    cy(3);
    chk(16'(tx_run_q), 16'h1);
    tx_evt.busy <= 1'b0;
    cy(3);
    chk(16'(tx_run_q), 16'h0);
    for (int h = 0; h < 2; h++) begin
      host.wr(4'h0, 2'h3, h ? 16'h1001 : 16'h0001);
      cy(2);
      pulse(7'h04);
      cy(3);
      chk(16'(tx_run_q), 16'(h == 0));
    end
    // Own carrier missing at end of preamble
    host.wr(4'h0, 2'h3, 16'h0401);
    tx_evt.busy <= 1'b1;
    pulse(7'h20);
    ab = 1'b0;
    repeat (8) @(negedge clk) ab |= abort_suppress_fcs_append_q;
    chk(16'(ab), 16'h1);
    tx_evt.busy <= 1'b0;
    cy(3);
    chk(16'(tx_run_q), 16'h0);
    host.wr(4'h0, 2'h3, 16'h0005);
    pulse(7'h10);
    rd(4'h0, 16'h0001);
    // Own-frame acceptance follows the duplex bit
    {rx_addr_pass, rx_from_self} <= 2'h3;
    for (int f = 0; f < 2; f++) begin
      host.wr(4'h0, 2'h3, f ? 16'h0800 : 16'h0000);
      cy(3);
      chk(16'(rx_accept_q), 16'(f));
    end
    // DMA passing the host pointer starves it
    early_tx_enable <= 1'b1;
    host_ptr <= 11'h100;
    dma_addr <= 11'h105;
    host.wr(4'h0, 2'h3, 16'h0001);
    cy(3);
    chk(16'(starve_dma_q), 16'h1);
    dma_addr <= 11'h0f0;
    cy(3);
    chk(16'(starve_dma_q), 16'h0);
    // Packet-aware style: same packet, transmit overtakes loading
    tx_laddr <= 11'h020;
    load_laddr <= 11'h010;
    host.wr(4'h0, 2'h3, 16'h4001);
    cy(3);
    chk(16'(starve_dma_q), 16'h1);
    load_laddr <= 11'h030;
    cy(3);
    chk(16'(starve_dma_q), 16'h0);
    cy(4);
    complete_run();
  end
endmodule // bank_tx_ctrl_tb

bind bank_tx_ctrl bank_tx_ctrl_monitor mon (.clk, .rst, .io_req,
  .power_down, .soft_rst, .tx_evt, .io_rdata_q, .bank_q, .cfg_q,
  .tx_run_q, .underrun_flag_q, .abort_suppress_fcs_append_q);

// file: verification/io_host_model.sv
/*
  Host processor on the 16-bit I/O bus.
  Assumes the block samples strobes on the rising clk edge.
*/
module io_host_model
  import tx_ctrl_pkg::*;
(
  input wire logic clk,
  output io_req_t io_req,
  output logic soft_rst
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    io_req = '0;
    soft_rst = 1'b0;
  end
  // One-cycle write; reserved transmit bit always written low
  task automatic wr(input logic [3:0] a, input logic [1:0] be,
      input logic [15:0] d);
    @(posedge clk);
    io_req.addr <= a;
    io_req.be <= be;
    io_req.wdata <= (a[3:1] == 3'h0) ? d & 16'hfff7 : d;
    io_req.wr <= 1'b1;
    @(posedge clk);
    io_req.wr <= 1'b0;
  endtask
  // One-cycle word read
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    io_req.addr <= a;
    io_req.be <= 2'h3;
    io_req.rd <= 1'b1;
    @(posedge clk);
    io_req.rd <= 1'b0;
  endtask
  // Leaving handler loopback needs a soft reset before normal use
  task automatic leave_loop();
    wr(4'h0, 2'h3, 16'h0000);
    soft_rst <= 1'b1;
    @(posedge clk);
    soft_rst <= 1'b0;
  endtask
endmodule // io_host_model
